// file: inc/flash_host_pkg.sv
// constants for the flash program/erase host controller
package flash_host_pkg;
    // ==================================================================
    // command codes and unlock addresses
    localparam logic [7:0] cmd_unlock2 = 8'h55;
    localparam logic [7:0] cmd_sector_erase = 8'h30;
    localparam logic [7:0] cmd_chip_erase = 8'h10;
    localparam logic [7:0] cmd_buffer_confirm = 8'h29;
    localparam logic [11:0] addr_unlock2 = 12'h2aa;
    localparam logic [11:0] addr_unlock1 = 12'h555;
    // ==================================================================
    // buffer word and byte counts
    localparam int buf_words_max = 16;
    localparam int buf_bytes_max = 32;
    // ==================================================================
    // bus timing (ns), converted to 10 ns cycles rounded up, with one extra cycle added to oe_cycles
    localparam int clk_period_ns = 10;
    localparam int t_wp_ns = 35;
    localparam int t_wph_ns = 30;
    localparam int t_oe_ns = 25;
    localparam int t_oeph_ns = 20;
    localparam int wp_cycles = (t_wp_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int wph_cycles = (t_wph_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int oe_cycles = (t_oe_ns + clk_period_ns - 1) / clk_period_ns + 1;
    localparam int oeph_cycles = (t_oeph_ns + clk_period_ns - 1) / clk_period_ns;
    // ==================================================================
    // operation codes on the user port
    localparam logic [1:0] op_sector_erase = 2'h0;
    localparam logic [1:0] op_chip_erase = 2'h1;
    localparam logic [1:0] op_word_program = 2'h2;
    localparam logic [1:0] op_buffer_commit = 2'h3;
    // status bit positions
    localparam int polling_bit_pos = 7;
    localparam int busy_toggle_pos = 6;
    localparam int suspend_toggle_pos = 2;
    // strobe select
    localparam logic strobe_we = 1'b0;
    localparam logic strobe_ce = 1'b1;
endpackage

// file: core/flash_pulse_timer.sv
// down counter that times one strobe phase of the flash bus
`timescale 1ns/1ps
module flash_pulse_timer #(
    parameter int width = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [width-1:0] count,
    // status
    output logic done
);
    // ==================================================================
    // counter
    logic [width-1:0] cnt_q; // remaining cycles
    logic [width-1:0] cnt_d;
    assign cnt_d = load ? count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
    // done reads only the count, so a loader may depend on it without a loop
    assign done = (cnt_q == '0);

    // count down, reload wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// file: core/flash_prog_host.sv
// host controller issuing final program/erase cycles and polling status
//
// Functional notes
// - sector erase: 55 at 2AA, 30 at sector
// - chip erase: 55 at 2AA, 10 at 555
// - buffer commit: 29 to sector address
// - word program, poll until true data
// - CE-controlled writes behave like WE
`timescale 1ns/1ps
module flash_prog_host #(
    parameter int addr_width = 22,
    parameter int data_width = 16,
    parameter int poll_limit = 1048576
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_op,
    input wire logic req_strobe_sel,
    input wire logic [addr_width-1:0] req_addr,
    input wire logic [data_width-1:0] req_data,
    input wire logic [5:0] req_buf_count,
    input wire logic req_byte_mode,
    // user result
    output logic done_pulse,
    output logic done_ok,
    output logic [data_width-1:0] last_status,
    // flash bus
    output logic [addr_width-1:0] flash_addr,
    output logic [data_width-1:0] dq_out,
    output logic dq_oe,
    input wire logic [data_width-1:0] dq_in,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    input wire logic ready_busy_n
);
    // ==================================================================
    // state machine
    typedef enum {st_idle, st_setup, st_strobe, st_recover, st_rd_low, st_rd_high, st_done} state_t;
    state_t state_q, state_d;

    logic [1:0] op_q; // operation in flight
    logic sel_q; // controlling strobe
    logic [addr_width-1:0] target_q; // sector or program address
    logic [data_width-1:0] data_q; // program word
    logic cycle_q; // which of two command cycles
    logic [addr_width-1:0] addr_q;
    logic [data_width-1:0] wdata_q;
    logic [data_width-1:0] status_q;
    logic [data_width-1:0] prev_q; // previous status read
    logic have_prev_q;
    logic ok_q;
    logic done_q;
    logic [20:0] poll_q; // poll attempts, bounded to avoid hanging
    logic ce_q, oe_q, we_q, dqoe_q;

    // ==================================================================
    // request decode
    wire buf_count_ok;
    wire [5:0] buf_limit;
    assign buf_limit = req_byte_mode ? 6'(flash_host_pkg::buf_bytes_max) : 6'(flash_host_pkg::buf_words_max);
    assign buf_count_ok = (req_op != flash_host_pkg::op_buffer_commit) ||
                          ((req_buf_count != 6'h00) && (req_buf_count <= buf_limit));
    assign req_ready = (state_q == st_idle);
    wire take = req_valid && req_ready;

    // command cycle contents per operation
    logic [addr_width-1:0] cyc_addr;
    logic [data_width-1:0] cyc_data;
    wire last_cycle;
    // sector erase / chip erase / buffer confirm / word program
    always_comb begin
        cyc_addr = target_q;
        cyc_data = data_q;
        case (op_q)
            flash_host_pkg::op_sector_erase: begin
                cyc_addr = cycle_q ? target_q : addr_width'(flash_host_pkg::addr_unlock2);
                cyc_data = cycle_q ? data_width'(flash_host_pkg::cmd_sector_erase)
                                   : data_width'(flash_host_pkg::cmd_unlock2);
            end
            flash_host_pkg::op_chip_erase: begin
                cyc_addr = cycle_q ? addr_width'(flash_host_pkg::addr_unlock1)
                                   : addr_width'(flash_host_pkg::addr_unlock2);
                cyc_data = cycle_q ? data_width'(flash_host_pkg::cmd_chip_erase)
                                   : data_width'(flash_host_pkg::cmd_unlock2);
            end
            flash_host_pkg::op_buffer_commit: begin
                cyc_addr = target_q;
                cyc_data = data_width'(flash_host_pkg::cmd_buffer_confirm);
            end
            default: begin
                cyc_addr = target_q;
                cyc_data = data_q;
            end
        endcase
    end
    // erases need two cycles, program and commit one
    assign last_cycle = cycle_q || (op_q == flash_host_pkg::op_word_program) ||
                        (op_q == flash_host_pkg::op_buffer_commit);

    // ==================================================================
    // status evaluation
    wire is_erase = (op_q == flash_host_pkg::op_sector_erase) || (op_q == flash_host_pkg::op_chip_erase);
    wire [data_width-1:0] expect_word = is_erase ? '1 : data_q;
    // polling bit matches written data only when finished
    wire polling_done = (dq_in[flash_host_pkg::polling_bit_pos] == expect_word[flash_host_pkg::polling_bit_pos]);
    // busy toggle compared between consecutive reads
    wire toggle_stopped = have_prev_q &&
        (dq_in[flash_host_pkg::busy_toggle_pos] == prev_q[flash_host_pkg::busy_toggle_pos]);
    // finished when ready, polling bit true and toggle still
    wire finished = ready_busy_n && polling_done && toggle_stopped;
    // word program must read back the true word
    wire verify_ok = (op_q != flash_host_pkg::op_word_program) || (dq_in == data_q);
    wire poll_expired = (poll_q == 21'(poll_limit));

    // ==================================================================
    // strobe timer
    logic tmr_load;
    logic [3:0] tmr_count;
    logic tmr_done;
    flash_pulse_timer #(.width(4)) u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // next state and timer loads
    always_comb begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_count = 4'h0;
        case (state_q)
            st_idle: begin
                if (take && buf_count_ok) begin
                    state_d = st_setup;
                end else if (take) begin
                    state_d = st_done;
                end
            end
            st_setup: begin
                state_d = st_strobe;
                tmr_load = 1'b1;
                tmr_count = 4'(flash_host_pkg::wp_cycles);
            end
            st_strobe: begin
                if (tmr_done) begin
                    state_d = st_recover;
                    tmr_load = 1'b1;
                    tmr_count = 4'(flash_host_pkg::wph_cycles);
                end
            end
            st_recover: begin
                if (tmr_done) begin
                    state_d = last_cycle ? st_rd_low : st_setup;
                    tmr_load = last_cycle;
                    tmr_count = 4'(flash_host_pkg::oe_cycles);
                end
            end
            st_rd_low: begin
                if (tmr_done) begin
                    state_d = (finished || poll_expired) ? st_done : st_rd_high;
                    tmr_load = 1'b1;
                    tmr_count = 4'(flash_host_pkg::oeph_cycles);
                end
            end
            st_rd_high: begin
                if (tmr_done) begin
                    state_d = st_rd_low;
                    tmr_load = 1'b1;
                    tmr_count = 4'(flash_host_pkg::oe_cycles);
                end
            end
            st_done: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // request capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_q <= flash_host_pkg::op_sector_erase;
            sel_q <= flash_host_pkg::strobe_we;
            target_q <= '0;
            data_q <= '0;
            ok_q <= 1'b0;
        end else if (take) begin
            op_q <= req_op;
            sel_q <= req_strobe_sel;
            target_q <= req_addr;
            data_q <= req_data;
            ok_q <= buf_count_ok;
        end else if (state_q == st_rd_low && tmr_done && (finished || poll_expired)) begin
            ok_q <= ok_q && finished && verify_ok;
        end
    end

    // command cycle counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cycle_q <= 1'b0;
        end else if (take) begin
            cycle_q <= 1'b0;
        end else if (state_q == st_recover && tmr_done) begin
            cycle_q <= 1'b1;
        end
    end

    // status sampling, one sample per read strobe
    // each read strobe yields a fresh toggle sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
            have_prev_q <= 1'b0;
            status_q <= '0;
            poll_q <= '0;
        end else if (take) begin
            have_prev_q <= 1'b0;
            poll_q <= '0;
        end else if (state_q == st_rd_low && tmr_done) begin
            prev_q <= dq_in;
            have_prev_q <= 1'b1;
            status_q <= dq_in;
            poll_q <= poll_q + 21'h000001;
        end
    end

    // ==================================================================
    // pin drive
    wire writing = (state_q == st_strobe);
    wire reading = (state_q == st_rd_low);
    wire bus_busy = (state_q != st_idle) && (state_q != st_done);
    // CE-controlled cycle drops WE one cycle before CE, except the first cycle following reset or a WE request, and raises both together
    // device drops ready_busy_n after this final rising strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ce_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            dqoe_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
        end else begin
            // status reads need the chip selected in either strobe mode
            ce_q <= !(state_d == st_strobe || state_d == st_rd_low);
            we_q <= (sel_q == flash_host_pkg::strobe_ce) ?
                    !(state_d == st_setup || state_d == st_strobe) : !(state_d == st_strobe);
            oe_q <= !(state_d == st_rd_low);
            dqoe_q <= (state_d == st_setup || state_d == st_strobe);
            // polling reads use the operating address
            addr_q <= (state_d == st_rd_low || state_d == st_rd_high) ? target_q : cyc_addr;
            wdata_q <= cyc_data;
        end
    end
    assign ce_n = ce_q;
    assign we_n = we_q;
    assign oe_n = oe_q;
    assign dq_oe = dqoe_q;
    assign dq_out = wdata_q;
    assign flash_addr = addr_q;

    // ==================================================================
    // result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == st_done);
        end
    end
    assign done_pulse = done_q;
    assign done_ok = ok_q;
    assign last_status = status_q;
endmodule

// file: dv/flash_prog_host_props.sv
// checker for the flash program/erase host controller
`timescale 1ns/1ps
module flash_prog_host_props #(
    parameter int addr_width = 22,
    parameter int data_width = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_op,
    input wire logic [5:0] req_buf_count,
    input wire logic done_pulse,
    input wire logic done_ok,
    // flash bus
    input wire logic [addr_width-1:0] flash_addr,
    input wire logic [data_width-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic ready_busy_n
);
    // ==========================================
    // bus phases
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // write strobe low on a selected device
    wire wr_low = !we_n && !ce_n;
    // ==========================================
    // assertions
    drive_write_a: assert property (wr_low |-> dq_oe) else $error("data not driven in write");
    release_read_a: assert property (!oe_n |-> !dq_oe) else $error("bus driven in read");
    no_overlap_a: assert property (!oe_n |-> we_n) else $error("read overlaps write");
    we_width_a: assert property ($fell(we_n) |-> (!we_n) [*4]) else $error("short write pulse");
    ce_width_a: assert property ($fell(ce_n) |-> (!ce_n) [*4]) else $error("short select pulse");
    oe_gap_a: assert property ($rose(oe_n) |-> oe_n [*2]) else $error("short read gap");
    take_busy_a: assert property (req_valid && req_ready |=> !req_ready) else $error("ready after take");
    // zero buffer count ends without any bus cycle
    refuse_pulse_a: assert property (req_valid && req_ready && req_op == flash_host_pkg::op_buffer_commit
        && req_buf_count == 6'h0 |-> ##2 (done_pulse && !done_ok && ce_n)) else $error("refusal late");
    done_ready_a: assert property (done_pulse && done_ok |-> ready_busy_n) else $error("ok while busy");
    hold_write_a: assert property (wr_low && $past(wr_low) |-> $stable(flash_addr) && $stable(dq_out))
        else $error("write changed");
    // main scenarios
    ok_c: cover property (done_pulse && done_ok);
    bad_c: cover property (done_pulse && !done_ok);
    cew_c: cover property ($fell(ce_n) && !we_n);
endmodule
bind flash_prog_host flash_prog_host_props #(.addr_width(addr_width), .data_width(data_width)) props_u (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_buf_count(req_buf_count), .done_pulse(done_pulse), .done_ok(done_ok), .flash_addr(flash_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .ready_busy_n(ready_busy_n));

// file: dv/flash_dev_model.sv
// behavioural flash device answering program/erase and status reads
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int busy_len = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // flash bus
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [15:0] dq_in,
    output logic ready_busy_n,
    // fault and write log
    input wire logic stuck,
    output logic [21:0] a0,
    output logic [21:0] a1,
    output logic [15:0] d0,
    output logic [15:0] d1,
    output int wr_cnt
);
    logic wr_q, rd_q, tog_q;
    logic [15:0] tgt_q, last_q;
    int busy_q;
    // either strobe may end a write
    wire wr_low = !ce_n && !we_n;
    wire rd_low = !ce_n && !oe_n;
    // complement on bit 7, no suspend so bit 2 stays still
    wire [15:0] stat = {tgt_q[15:8], ~tgt_q[7], tog_q, tgt_q[5:3], 1'b0, tgt_q[1:0]};
    assign ready_busy_n = (busy_q == 0);
    // released bus shows the inverse of the last value, never a friendly one
    assign dq_in = dq_oe ? dq_out : rd_low ? (busy_q != 0 ? stat : tgt_q) : ~last_q;
    // strobe edges, write log, algorithm timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {wr_q, rd_q, tog_q, tgt_q, last_q, a0, a1, d0, d1} <= '0;
            wr_cnt <= 0;
            busy_q <= 0;
        end else begin
            wr_q <= wr_low;
            rd_q <= rd_low;
            if (rd_low) last_q <= dq_in;
            if (busy_q > 0 && !stuck) busy_q <= busy_q - 1;
            // toggle on every read end, any address
            if (rd_q && !rd_low) tog_q <= !tog_q;
            if (wr_q && !wr_low) begin
                {a0, d0, a1, d1} <= {a1, d1, flash_addr, dq_out};
                wr_cnt <= wr_cnt + 1;
                if (dq_out[7:0] != 8'h55) begin
                    busy_q <= busy_len;
                    tgt_q <= (dq_out[7:0] inside {8'h30, 8'h10, 8'h29}) ? 16'hffff : dq_out;
                end
            end
        end
    end
endmodule

// file: dv/flash_prog_host_bench.sv
// testbench for the flash program/erase host controller
`timescale 1ns/1ps
module flash_prog_host_bench;
    logic clk, rst, req_valid, req_ready, req_strobe_sel, req_byte_mode, done_pulse, done_ok;
    logic dq_oe, ce_n, oe_n, we_n, rbn, stuck;
    logic [1:0] req_op;
    logic [21:0] req_addr, flash_addr, a0, a1;
    logic [15:0] req_data, last_status, dq_out, dq_in, d0, d1;
    logic [5:0] req_buf_count;
    int wr_cnt, n_mismatch, samples_checked;
    // ==========================================
    // design, device model, clock
    flash_prog_host #(.poll_limit(64)) dut_u (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_strobe_sel(req_strobe_sel), .req_addr(req_addr),
        .req_data(req_data), .req_buf_count(req_buf_count), .req_byte_mode(req_byte_mode),
        .done_pulse(done_pulse), .done_ok(done_ok), .last_status(last_status), .flash_addr(flash_addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .ready_busy_n(rbn));
    flash_dev_model model_u (.clk(clk), .rst(rst), .flash_addr(flash_addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in), .ready_busy_n(rbn),
        .stuck(stuck), .a0(a0), .a1(a1), .d0(d0), .d1(d1), .wr_cnt(wr_cnt));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // ==========================================
    // shared tasks
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // one request, driven at the falling edge, awaited under a bound
    task automatic do_op(input logic [1:0] op, input logic sel, input logic [21:0] ad, input logic [15:0] dt,
        input logic [5:0] cnt, input logic bm, input logic exp_ok, input int nwr);
        int n, w;
        w = wr_cnt;
        @(negedge clk);
        {req_valid, req_op, req_strobe_sel, req_addr, req_data, req_buf_count, req_byte_mode} =
            {1'b1, op, sel, ad, dt, cnt, bm};
        @(negedge clk);
        req_valid = 0;
        n = 0;
        while (done_pulse !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check(n < 5000, 1, "no completion");
        check(done_ok, exp_ok, "completion status");
        check(wr_cnt - w, nwr, "bus write count");
    endtask
    // ==========================================
    // scenarios
    task t_sector;
        do_op(flash_host_pkg::op_sector_erase, flash_host_pkg::strobe_we, 22'h012000, 16'h0, 6'h0, 0, 1, 2);
        check({a0, d0[7:0]}, {22'h0002aa, 8'h55}, "sector unlock");
        check({a1, d1[7:0]}, {22'h012000, 8'h30}, "sector code");
        check(last_status, 16'hffff, "erase status");
    endtask
    task t_chip;
        do_op(flash_host_pkg::op_chip_erase, flash_host_pkg::strobe_ce, 22'h000555, 16'h0, 6'h0, 0, 1, 2);
        check({a0, d0[7:0]}, {22'h0002aa, 8'h55}, "chip unlock");
        check({a1, d1[7:0]}, {22'h000555, 8'h10}, "chip code");
    endtask
    task t_prog;
        do_op(flash_host_pkg::op_word_program, flash_host_pkg::strobe_we, 22'h000123, 16'ha5c3, 6'h0, 0, 1, 1);
        check({a1, d1}, {22'h000123, 16'ha5c3}, "program cycle");
        check(last_status, 16'ha5c3, "true data");
    endtask
    task t_commit;
        for (int i = 0; i < 3; i++) begin
            do_op(flash_host_pkg::op_buffer_commit, i[0], 22'h034000, 16'hffff, i == 0 ? 6'h01 : i == 1 ? 6'h10 :
                6'h20, i == 2, 1, 1);
            check({a1, d1[7:0]}, {22'h034000, 8'h29}, "confirm code");
        end
    endtask
    task t_refuse;
        do_op(flash_host_pkg::op_buffer_commit, 0, 22'h034000, 16'hffff, 6'h00, 0, 0, 0);
        do_op(flash_host_pkg::op_buffer_commit, 0, 22'h034000, 16'hffff, 6'h11, 0, 0, 0);
        do_op(flash_host_pkg::op_buffer_commit, 0, 22'h034000, 16'hffff, 6'h21, 1, 0, 0);
    endtask
    task t_stuck;
        stuck = 1;
        do_op(flash_host_pkg::op_word_program, flash_host_pkg::strobe_we, 22'h000200, 16'h1234, 6'h0, 0, 0, 1);
        check(rbn, 0, "busy pin");
        stuck = 0;
        repeat (60) @(negedge clk);
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        {req_valid, req_op, req_strobe_sel, req_addr, req_data, req_buf_count, req_byte_mode, stuck} = '0;
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        t_sector();
        t_chip();
        t_prog();
        t_commit();
        t_refuse();
        t_stuck();
        test_done();
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule
